// *** csw_pkg.sv ***
/*
 Constants, packed carriers and state encodings for the clock supervisor.
 Assumes one 100 MHz clock; oscillator level and VCO ticks arrive as inputs.
*/
// What this block does
// - start quality check on POR, low-voltage, stop-exit, fail
// - check window is 50000 VCO cycles
// - 4096 oscillator edges means good, ends window
// - checker keeps running beside self-clock handling
// - monitor reset forces self-clock enable to one
// - PLL and regulator on while checking, wait too
// - watchdog off after reset, seven rates, resets
// - keys 0x55 then 0xAA restart watchdog period
// - any other service value resets at once
// - windowed mode: early service resets the part
// - watchdog runs in pseudo-stop when enabled
// - periodic end sets flag, restarts, irq if enabled
// - writing periodic rate restarts the period
// - periodic timer runs in pseudo-stop when enabled
// - self-clock entry needs both enables, clears PLL select
// - zero rate code stops each timer
// - each wait bit gates its own unit; sys bit stops core too
// - wait entry: deselect PLL, PLL, core, system off
// - external reset restores defaults, normal vector
// - fail in wait without self-clock gives monitor reset
// - fail with self-clock: flag, mode, check, irq wake
// - other wake resumes; PLL select stays cleared
// - no oscillator edges for a while reports failure
package csw_pkg;
    localparam int          CSW_CLK_MHZ       = 100;
    localparam int          CSW_WIN_W         = 16;
    localparam int          CSW_EDGE_W        = 13;
    localparam int          CSW_CNT_W         = 28;
    localparam int          CSW_RATE_W        = 4;
    localparam int          CSW_SH_W          = 5;
    localparam int          CSW_CHECK_WINDOW  = 50000;
    localparam int          CSW_MON_TIMEOUT   = 64;
    localparam logic [12:0] CSW_OSC_OK_EDGES  = 13'h1000;
    localparam logic [15:0] CSW_KEY_ARM       = 16'h0055;
    localparam logic [15:0] CSW_KEY_FIRE      = 16'h00AA;
    localparam logic [4:0]  CSW_WD_BASE_SHIFT = 5'h0D;
    localparam logic [4:0]  CSW_PIT_BASE_SHIFT = 5'h09;
    localparam logic [7:0]  CSW_MON_W         = 8'hFF;
    localparam logic        CSW_SELF_CLOCK_ENABLE_RST      = 1'b1;

    typedef struct packed {
        logic pll;
        logic core;
        logic sys;
        logic pit;
        logic wd;
        logic roa;
    } csw_wait_cfg_t;

    typedef struct packed {
        logic [2:0] rate;
        logic       window;
        logic       pstop;
    } csw_wd_cfg_t;

    typedef struct packed {
        logic [CSW_RATE_W-1:0] rate;
        logic                  irq_en;
        logic                  pstop;
    } csw_pit_cfg_t;

    typedef enum logic [2:0] {
        CSW_W_RUN      = 3'h0,
        CSW_W_SEL_OSC  = 3'h1,
        CSW_W_PLL_OFF  = 3'h3,
        CSW_W_CORE_OFF = 3'h2,
        CSW_W_SYS_OFF  = 3'h6,
        CSW_W_ACTIVE   = 3'h7
    } csw_wait_st_t;

    typedef enum logic [1:0] {
        CSW_RC_NONE = 2'h0,
        CSW_RC_WDOG = 2'h1,
        CSW_RC_MON  = 2'h3
    } csw_cause_t;
endpackage

// *** csw_rate_timer.sv ***
/*
 Rate-coded period timer used for the watchdog and the periodic timer.
 Assumes restart and run are synchronous single-clock controls.
*/
`timescale 1ns/1ps
module csw_rate_timer import csw_pkg::*; (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // control
    input  wire logic [CSW_RATE_W-1:0] rate,
    input  wire logic [CSW_SH_W-1:0]   base_shift,
    input  wire logic                  restart,
    input  wire logic                  run,
    // status
    output logic                       expire_q,
    output logic                       late_q
);
    logic [CSW_CNT_W-1:0] cnt_q;
    logic [CSW_CNT_W-1:0] period;
    logic [CSW_SH_W-1:0]  sh;

    // table: code n gives 2^(base+n-1) ticks
    always_comb begin
        sh     = base_shift + CSW_SH_W'(rate) - 5'h01;
        period = CSW_CNT_W'(1) << sh;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q    <= '0;
            expire_q <= 1'b0;
        end else begin
            expire_q <= 1'b0;
            if (restart || rate == '0) begin
                cnt_q <= '0;
            end else if (run) begin
                if (cnt_q == period - 1'b1) begin
                    cnt_q    <= '0;
                    expire_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) late_q <= 1'b0;
        else late_q <= (rate != '0) && (cnt_q >= period - (period >> 2));
    end

    chk_zero_rate_idle: assert property (@(posedge clk) disable iff (!nrst)
        (rate == '0) |=> !expire_q) else $error("timer expired while stopped");
endmodule // csw_rate_timer

// *** csw_quality_check.sv ***
/*
 Clock quality checker: counts oscillator edges within a VCO-tick window.
 Assumes osc_edge is already synchronised and one cycle wide.
*/
`timescale 1ns/1ps
module csw_quality_check import csw_pkg::*; #(
    parameter int CHECK_WINDOW = CSW_CHECK_WINDOW
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // events
    input  wire logic start,
    input  wire logic retry,
    input  wire logic osc_edge,
    input  wire logic vco_tick,
    // result
    output logic      busy_q,
    output logic      ok_q,
    output logic      fail_q
);
    localparam logic [CSW_WIN_W-1:0] WIN_LAST = CSW_WIN_W'(CHECK_WINDOW - 1);
    logic [CSW_WIN_W-1:0]  win_q;
    logic [CSW_EDGE_W-1:0] edge_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
            ok_q   <= 1'b0;
            fail_q <= 1'b0;
            win_q  <= '0;
            edge_q <= '0;
        end else begin
            ok_q   <= 1'b0;
            fail_q <= 1'b0;
            if (start) begin
                busy_q <= 1'b1;
                win_q  <= '0;
                edge_q <= '0;
            end else if (busy_q) begin
                if (osc_edge && edge_q == CSW_OSC_OK_EDGES - 1'b1) begin
                    busy_q <= 1'b0;
                    ok_q   <= 1'b1;
                end else if (vco_tick && win_q == WIN_LAST) begin
                    fail_q <= 1'b1;
                    busy_q <= retry;
                    win_q  <= '0;
                    edge_q <= '0;
                end else begin
                    win_q  <= win_q + CSW_WIN_W'(vco_tick);
                    edge_q <= edge_q + CSW_EDGE_W'(osc_edge);
                end
            end
        end
    end

    chk_ok_ends_window: assert property (@(posedge clk) disable iff (!nrst)
        ok_q |-> !busy_q) else $error("window kept open after osc ok");
endmodule // csw_quality_check

// *** csw_clock_supervisor.sv ***
/*
 Clock supervisor top: monitor, self-clock mode, watchdog, periodic timer,
 wait-mode clock gating and reset requests.
 Assumes osc_level is the raw oscillator seen at clk and vco_tick pulses
 once per minimum-frequency VCO cycle; software strobes are one cycle.
*/
`timescale 1ns/1ps
module csw_clock_supervisor import csw_pkg::*; #(
    parameter int CHECK_WINDOW_VCO = CSW_CHECK_WINDOW,
    parameter int MON_TIMEOUT_VCO  = CSW_MON_TIMEOUT
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // clock sources and reset events
    input  wire logic          osc_level,
    input  wire logic          vco_tick,
    input  wire logic          power_on_reset,
    input  wire logic          low_voltage_reset,
    input  wire logic          stop_exit_full,
    input  wire logic          pseudo_stop_active,
    // clock control
    input  wire logic          clock_monitor_enable,
    input  wire logic          self_clock_enable_wr,
    input  wire logic          self_clock_enable_in,
    input  wire logic          self_clock_irq_enable,
    input  wire logic          self_clock_flag_clear,
    input  wire logic          pll_clock_select_set,
    input  wire logic          pll_clock_select_clear,
    // watchdog
    input  wire logic          watchdog_control_wr,
    input  wire csw_wd_cfg_t   watchdog_control_in,
    input  wire logic          watchdog_service_wr,
    input  wire logic [15:0]   watchdog_service_data,
    // periodic timer
    input  wire logic          periodic_rate_wr,
    input  wire csw_pit_cfg_t  periodic_rate_in,
    input  wire logic          periodic_flag_clear,
    // wait mode
    input  wire csw_wait_cfg_t wait_cfg,
    input  wire logic          wait_instruction,
    input  wire logic          wake_irq,
    // outputs
    output logic               osc_good_q,
    output logic               qc_busy_q,
    output logic               pll_enable_q,
    output logic               voltage_regulator_en_q,
    output logic               pll_clock_select_q,
    output logic               self_clock_mode_q,
    output logic               self_clock_enable_q,
    output logic               self_clock_flag_q,
    output logic               self_clock_irq_q,
    output logic               periodic_flag_q,
    output logic               periodic_irq_q,
    output logic               core_clk_en_q,
    output logic               sys_clk_en_q,
    output logic               reduced_osc_amp_q,
    output logic               wait_active_q,
    output logic               system_reset_q,
    output csw_cause_t         reset_cause_q
);
    localparam logic [CSW_WIN_W-1:0] MON_LAST = CSW_WIN_W'(MON_TIMEOUT_VCO - 1);

    logic osc_s1_q;
    logic osc_s2_q;
    logic osc_s3_q;
    logic osc_edge;
    logic [CSW_WIN_W-1:0] mon_cnt_q;
    logic mon_lost_q;
    logic mon_fail;
    logic qc_start;
    logic qc_ok;
    logic qc_fail;
    logic scm_enter;
    logic mon_reset;
    logic wd_reset;
    csw_wait_st_t wst_q;
    logic in_wait;
    logic wake;
    logic pll_off_q;
    csw_wd_cfg_t wd_cfg_q;
    csw_pit_cfg_t pit_cfg_q;
    logic wd_armed_q;
    logic wd_restart;
    logic wd_bad;
    logic wd_run;
    logic wd_expire;
    logic wd_late;
    logic pit_run;
    logic pit_expire;

    // sync; stage one feeds stage two only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_level;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end
    assign osc_edge = osc_s2_q & ~osc_s3_q;

    // missing-edge detector counted in VCO ticks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mon_cnt_q  <= '0;
            mon_lost_q <= 1'b0;
        end else if (osc_edge || !clock_monitor_enable) begin
            mon_cnt_q  <= '0;
            mon_lost_q <= 1'b0;
        end else if (vco_tick && !mon_lost_q) begin
            if (mon_cnt_q == MON_LAST) mon_lost_q <= 1'b1;
            else mon_cnt_q <= mon_cnt_q + 1'b1;
        end
    end
    // one pulse per loss, only on the tick that hits the limit
    assign mon_fail  = clock_monitor_enable && vco_tick && !mon_lost_q &&
                       !osc_edge && mon_cnt_q == MON_LAST;
    assign scm_enter = mon_fail && self_clock_enable_q;
    assign mon_reset = mon_fail && !self_clock_enable_q;

    assign qc_start = power_on_reset | low_voltage_reset | stop_exit_full | mon_fail;

    csw_quality_check #(
        .CHECK_WINDOW (CHECK_WINDOW_VCO)
    ) u_qc (
        .clk      (clk),
        .nrst     (nrst),
        .start    (qc_start),
        .retry    (self_clock_mode_q),
        .osc_edge (osc_edge),
        .vco_tick (vco_tick),
        .busy_q   (qc_busy_q),
        .ok_q     (qc_ok),
        .fail_q   (qc_fail)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) osc_good_q <= 1'b0;
        else if (qc_start || qc_fail) osc_good_q <= 1'b0;
        else if (qc_ok) osc_good_q <= 1'b1;
    end

    // self-clock mode; leaves it on its own once the oscillator checks good
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) self_clock_mode_q <= 1'b0;
        else if (scm_enter) self_clock_mode_q <= 1'b1;
        else if (qc_ok) self_clock_mode_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) self_clock_enable_q <= CSW_SELF_CLOCK_ENABLE_RST;
        else if (mon_reset) self_clock_enable_q <= 1'b1;
        else if (self_clock_enable_wr) self_clock_enable_q <= self_clock_enable_in;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) self_clock_flag_q <= 1'b0;
        else if (scm_enter) self_clock_flag_q <= 1'b1;
        else if (self_clock_flag_clear) self_clock_flag_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) self_clock_irq_q <= 1'b0;
        else self_clock_irq_q <= self_clock_flag_q && self_clock_irq_enable;
    end

    // hardware clears beat a software set
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) pll_clock_select_q <= 1'b0;
        else if (scm_enter) pll_clock_select_q <= 1'b0;
        else if (wst_q == CSW_W_SEL_OSC && wait_cfg.pll) pll_clock_select_q <= 1'b0;
        else if (pll_clock_select_clear) pll_clock_select_q <= 1'b0;
        else if (pll_clock_select_set && !self_clock_mode_q) pll_clock_select_q <= 1'b1;
    end

    // wait entry walks the clocks down in order
    assign in_wait = wst_q != CSW_W_RUN;
    assign wake    = wake_irq || (self_clock_irq_q && wst_q == CSW_W_ACTIVE);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wst_q <= CSW_W_RUN;
        end else if (mon_reset || wd_reset) begin
            wst_q <= CSW_W_RUN;
        end else begin
            case (wst_q)
                CSW_W_RUN:      if (wait_instruction) wst_q <= CSW_W_SEL_OSC;
                CSW_W_SEL_OSC:  wst_q <= CSW_W_PLL_OFF;
                CSW_W_PLL_OFF:  wst_q <= CSW_W_CORE_OFF;
                CSW_W_CORE_OFF: wst_q <= CSW_W_SYS_OFF;
                CSW_W_SYS_OFF:  wst_q <= CSW_W_ACTIVE;
                CSW_W_ACTIVE:   if (wake) wst_q <= CSW_W_RUN;
                default:        wst_q <= CSW_W_RUN;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) wait_active_q <= 1'b0;
        else wait_active_q <= wst_q == CSW_W_ACTIVE && !wake;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) pll_off_q <= 1'b0;
        else if (!in_wait) pll_off_q <= 1'b0;
        else if (wst_q == CSW_W_PLL_OFF && wait_cfg.pll) pll_off_q <= 1'b1;
    end

    // a running check keeps PLL and regulator up, in wait or pseudo-stop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pll_enable_q           <= 1'b1;
            voltage_regulator_en_q <= 1'b1;
        end else begin
            pll_enable_q <= !(pll_off_q || pseudo_stop_active) ||
                            qc_busy_q || self_clock_mode_q;
            voltage_regulator_en_q <= !pseudo_stop_active || qc_busy_q ||
                                      self_clock_mode_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_clk_en_q     <= 1'b1;
            sys_clk_en_q      <= 1'b1;
            reduced_osc_amp_q <= 1'b0;
        end else if (!in_wait || wake) begin
            core_clk_en_q     <= 1'b1;
            sys_clk_en_q      <= 1'b1;
            reduced_osc_amp_q <= 1'b0;
        end else begin
            if (wst_q == CSW_W_CORE_OFF && (wait_cfg.core || wait_cfg.sys))
                core_clk_en_q <= 1'b0;
            if (wst_q == CSW_W_SYS_OFF && wait_cfg.sys)
                sys_clk_en_q <= 1'b0;
            if (wst_q == CSW_W_ACTIVE)
                reduced_osc_amp_q <= wait_cfg.roa;
        end
    end

    // watchdog: control held at zero out of reset, so it starts disabled
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) wd_cfg_q <= '0;
        else if (watchdog_control_wr) wd_cfg_q <= watchdog_control_in;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) pit_cfg_q <= '0;
        else if (periodic_rate_wr) pit_cfg_q <= periodic_rate_in;
    end

    // windowed mode: any service write before the last quarter is fatal
    always_comb begin
        wd_restart = 1'b0;
        wd_bad     = 1'b0;
        if (watchdog_service_wr && wd_cfg_q.rate != 3'h0) begin
            if (wd_cfg_q.window && !wd_late) begin
                wd_bad = 1'b1;
            end else if (watchdog_service_data == CSW_KEY_FIRE && wd_armed_q) begin
                wd_restart = 1'b1;
            end else if (watchdog_service_data != CSW_KEY_ARM &&
                         watchdog_service_data != CSW_KEY_FIRE) begin
                wd_bad = 1'b1;
            end
        end
    end

    // an out-of-order 0xAA only drops the arming
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) wd_armed_q <= 1'b0;
        else if (watchdog_service_wr) wd_armed_q <= watchdog_service_data == CSW_KEY_ARM;
    end

    assign wd_run = !(wait_active_q && wait_cfg.wd) &&
                    !(pseudo_stop_active && !wd_cfg_q.pstop);

    csw_rate_timer u_wd (
        .clk        (clk),
        .nrst       (nrst),
        .rate       ({1'b0, wd_cfg_q.rate}),
        .base_shift (CSW_WD_BASE_SHIFT),
        .restart    (wd_restart || watchdog_control_wr),
        .run        (wd_run),
        .expire_q   (wd_expire),
        .late_q     (wd_late)
    );

    assign wd_reset = wd_expire || wd_bad;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            system_reset_q <= 1'b0;
            reset_cause_q  <= CSW_RC_NONE;
        end else begin
            system_reset_q <= wd_reset || mon_reset;
            if (mon_reset) reset_cause_q <= CSW_RC_MON;
            else if (wd_reset) reset_cause_q <= CSW_RC_WDOG;
        end
    end

    // periodic timer
    assign pit_run = !(wait_active_q && wait_cfg.pit) &&
                     !(pseudo_stop_active && !pit_cfg_q.pstop);

    csw_rate_timer u_pit (
        .clk        (clk),
        .nrst       (nrst),
        .rate       (pit_cfg_q.rate),
        .base_shift (CSW_PIT_BASE_SHIFT),
        .restart    (periodic_rate_wr),
        .run        (pit_run),
        .expire_q   (pit_expire),
        .late_q     ()
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) periodic_flag_q <= 1'b0;
        else if (pit_expire) periodic_flag_q <= 1'b1;
        else if (periodic_flag_clear) periodic_flag_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) periodic_irq_q <= 1'b0;
        else periodic_irq_q <= periodic_flag_q && pit_cfg_q.irq_en;
    end

    sequence s_wait_walk;
        wst_q == CSW_W_SEL_OSC ##1 wst_q == CSW_W_PLL_OFF ##1
        wst_q == CSW_W_CORE_OFF ##1 wst_q == CSW_W_SYS_OFF;
    endsequence

    chk_wait_order: assert property (@(posedge clk) disable iff (!nrst)
        (wst_q == CSW_W_RUN && wait_instruction && !mon_reset && !wd_reset) |=>
        s_wait_walk) else $error("wait entry out of order");
    chk_scm_clears_pll: assert property (@(posedge clk) disable iff (!nrst)
        scm_enter |=> !pll_clock_select_q && self_clock_mode_q && self_clock_flag_q)
        else $error("self-clock entry incomplete");
    chk_mon_reset: assert property (@(posedge clk) disable iff (!nrst)
        mon_reset |=> system_reset_q && reset_cause_q == CSW_RC_MON && self_clock_enable_q)
        else $error("monitor reset missing");
    chk_bad_key: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_service_wr && wd_cfg_q.rate != 3'h0 && !wd_cfg_q.window &&
         watchdog_service_data != CSW_KEY_ARM && watchdog_service_data != CSW_KEY_FIRE)
        |=> system_reset_q) else $error("bad key did not reset");
    chk_early_service: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_service_wr && wd_cfg_q.rate != 3'h0 && wd_cfg_q.window && !wd_late)
        |=> system_reset_q) else $error("early service did not reset");
    chk_key_pair: assert property (@(posedge clk) disable iff (!nrst)
        (watchdog_service_wr && watchdog_service_data == CSW_KEY_FIRE && wd_armed_q &&
         (!wd_cfg_q.window || wd_late) && wd_cfg_q.rate != 3'h0 && !wd_expire && !mon_reset)
        |=> !system_reset_q) else $error("valid key pair reset the part");
    chk_pit_flag: assert property (@(posedge clk) disable iff (!nrst)
        pit_expire |=> periodic_flag_q ##1 (periodic_irq_q == pit_cfg_q.irq_en) or
        (periodic_flag_q ##1 $past(periodic_rate_wr)))
        else $error("periodic flag not raised");
    chk_check_power: assert property (@(posedge clk) disable iff (!nrst)
        qc_busy_q |=> pll_enable_q && voltage_regulator_en_q)
        else $error("check ran with PLL or regulator off");
    chk_quality_start: assert property (@(posedge clk) disable iff (!nrst)
        qc_start |=> qc_busy_q) else $error("quality check not started");
    chk_wd_disabled: assert property (@(posedge clk) disable iff (!nrst)
        wd_cfg_q.rate == 3'h0 && !watchdog_control_wr |=> !wd_expire)
        else $error("stopped watchdog expired");
endmodule // csw_clock_supervisor

// *** csw_osc_model.sv ***
/*
 Far-side source model: oscillator with a stop control, and min-frequency VCO ticks.
 Assumes clk is the 100 MHz system clock of the supervisor.
*/
`timescale 1ns/1ps
module csw_osc_model #(
    parameter int VCO_DIV = 128
) (
    // clock and control
    input  wire logic clk,
    input  wire logic osc_run,
    // sources
    output logic      osc_level = 1'b0,
    output logic      vco_tick
);
    int div_q = 0;
    // a dead crystal stalls at its last level; edges fall on clk falling edges, never on rising ones
    always #20 osc_level = osc_run ? ~osc_level : osc_level;
    always @(posedge clk) begin
        div_q    <= (div_q + 1) % VCO_DIV;
        vco_tick <= (div_q == 0);
    end
endmodule // csw_osc_model

// *** csw_clock_supervisor_tb_top.sv ***
/*
 Self-checking bench: quality check, watchdog, periodic timer, wait and self-clock.
 Assumes csw_osc_model drives oscillator and VCO ticks; inputs change at negedge.
*/
`timescale 1ns/1ps
module csw_clock_supervisor_tb_top import csw_pkg::*; ;
    logic clk = 0, nrst = 0, osc_run = 1, clock_monitor_enable = 1, osc_level, vco_tick;
    logic power_on_reset = 0, low_voltage_reset = 0, stop_exit_full = 0, pseudo_stop_active = 0;
    logic self_clock_enable_wr = 0, self_clock_enable_in = 0, self_clock_irq_enable = 0;
    logic self_clock_flag_clear = 0, pll_clock_select_set = 0, pll_clock_select_clear = 0;
    logic watchdog_control_wr = 0, watchdog_service_wr = 0, periodic_rate_wr = 0;
    logic periodic_flag_clear = 0, wait_instruction = 0, wake_irq = 0;
    logic [15:0]   watchdog_service_data = '0;
    csw_wd_cfg_t   watchdog_control_in = '0;
    csw_pit_cfg_t  periodic_rate_in = '0;
    csw_wait_cfg_t wait_cfg = '0;
    logic osc_good_q, qc_busy_q, pll_enable_q, voltage_regulator_en_q, pll_clock_select_q;
    logic self_clock_mode_q, self_clock_enable_q, self_clock_flag_q, self_clock_irq_q;
    logic periodic_flag_q, periodic_irq_q, core_clk_en_q, sys_clk_en_q, reduced_osc_amp_q;
    logic wait_active_q, system_reset_q;
    csw_cause_t    reset_cause_q;
    int errors = 0, tests_run = 0, resets = 0, cyc = 0;

    // short window and monitor timeout keep the run brief
    csw_clock_supervisor #(.CHECK_WINDOW_VCO(200), .MON_TIMEOUT_VCO(4)) i_csw_clock_supervisor (.*);
    csw_osc_model i_csw_osc_model (.clk, .osc_run, .osc_level, .vco_tick);

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (system_reset_q === 1'b1) resets <= resets + 1;
        if (cyc == 80000) begin
            errors++;
            final_report();
        end
    end

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wt(input string n, ref logic s, input logic v, input int lim);
        for (int i = 0; i < lim && s !== v; i++) @(negedge clk);
        chk(n, {7'h0, v}, {7'h0, s});
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic svc(input logic [15:0] d);
        watchdog_service_data = d;
        pulse(watchdog_service_wr);
        @(negedge clk);
    endtask
    task automatic final_report;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (12) @(negedge clk);
        nrst = 1;
        chk("rst", 8'h3E, {2'h0, pll_enable_q, voltage_regulator_en_q, core_clk_en_q,
            sys_clk_en_q, self_clock_enable_q, osc_good_q});
        pulse(power_on_reset);
        wt("busy", qc_busy_q, 1, 3);
        repeat (16000) @(negedge clk);
        chk("good_early", 8'h00, {7'h0, osc_good_q});
        wt("good", osc_good_q, 1, 1000);
        watchdog_control_in = '{3'h1, 1'b0, 1'b0};
        pulse(watchdog_control_wr);
        repeat (4000) @(negedge clk);
        svc(16'h0055);
        svc(16'h00AA);
        repeat (6000) @(negedge clk);
        chk("wd_kept", 8'h00, resets[7:0]);
        repeat (2400) @(negedge clk);
        chk("wd_expire", 8'h01, resets[7:0]);
        svc(16'h0012);
        repeat (2) @(negedge clk);
        chk("wd_badkey", 8'h02, resets[7:0]);
        chk("cause", 8'h01, {6'h0, reset_cause_q});
        watchdog_control_in = '{3'h1, 1'b1, 1'b0};
        pulse(watchdog_control_wr);
        svc(16'h0055);
        repeat (2) @(negedge clk);
        chk("wd_window", 8'h03, resets[7:0]);
        watchdog_control_in = '0;
        pulse(watchdog_control_wr);
        periodic_rate_in = '{4'h1, 1'b1, 1'b0};
        pulse(periodic_rate_wr);
        repeat (500) @(negedge clk);
        chk("pit_early", 8'h00, {7'h0, periodic_flag_q});
        wt("pit_flag", periodic_flag_q, 1, 20);
        wt("pit_irq", periodic_irq_q, 1, 2);
        periodic_rate_in = '0;
        pulse(periodic_rate_wr);
        pulse(periodic_flag_clear);
        pulse(pll_clock_select_set);
        wait_cfg = '1;
        pulse(wait_instruction);
        repeat (7) @(negedge clk);
        chk("wait", 8'h03, {2'h0, core_clk_en_q, sys_clk_en_q, pll_clock_select_q,
            pll_enable_q, reduced_osc_amp_q, wait_active_q});
        pulse(wake_irq);
        repeat (2) @(negedge clk);
        chk("woke", 8'h0C, {4'h0, core_clk_en_q, sys_clk_en_q, pll_clock_select_q,
            wait_active_q});
        self_clock_irq_enable = 1;
        pulse(wait_instruction);
        repeat (7) @(negedge clk);
        osc_run = 0;
        wt("scm", self_clock_mode_q, 1, 1500);
        @(negedge clk);
        chk("scm_st", 8'h3C, {2'h0, self_clock_irq_q, self_clock_flag_q, pll_enable_q,
            voltage_regulator_en_q, pll_clock_select_q, system_reset_q});
        wt("scm_wake", core_clk_en_q, 1, 5);
        osc_run = 1;
        wt("scm_exit", self_clock_mode_q, 0, 17000);
        pulse(self_clock_flag_clear);
        pulse(low_voltage_reset);
        wt("lvr_busy", qc_busy_q, 1, 3);
        pulse(self_clock_enable_wr);
        pulse(wait_instruction);
        repeat (7) @(negedge clk);
        osc_run = 0;
        wt("cm_rst", system_reset_q, 1, 1500);
        @(negedge clk);
        chk("cm_cause", 8'h0B, {4'h0, self_clock_enable_q, wait_active_q, reset_cause_q});
        osc_run = 1;
        chk("resets", 8'h04, resets[7:0]);
        final_report();
    end
endmodule // csw_clock_supervisor_tb_top
